// *** verilog/ccd_defines.svh ***
// register map, field positions, reset values and operation codes
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CCD_ADDR_W       8
`define CCD_REG_ISSUE    8'h00
`define CCD_REG_ACC      8'h04
`define CCD_REG_PC       8'h08
`define CCD_REG_PCH      8'h0C
`define CCD_REG_STAT     8'h10
`define CCD_REG_FADDR    8'h14
`define CCD_REG_FDATA    8'h18
`define CCD_REG_WDT      8'h1C
`define CCD_REG_TOP      8'h20

// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define CCD_ST_Z         0
`define CCD_ST_PD        1
`define CCD_ST_TO        2
`define CCD_ST_BUSY      3
`define CCD_ST_SKIP      4
`define CCD_ST_DEPTH_LO  5
`define CCD_RST_TO       1'b1
`define CCD_RST_PD       1'b1
`define CCD_RST_Z        1'b0
`define CCD_STACK_DEPTH  5'h10

// ----------------------------------------------------------------
// operation codes in issue word bits 2:0
// ----------------------------------------------------------------
`define CCD_OP_NONE      3'h0
`define CCD_OP_WDCLR     3'h1
`define CCD_OP_ACALL     3'h2
`define CCD_OP_INV       3'h3
`define CCD_OP_ZREG      3'h4
`define CCD_OP_DEC       3'h5
`define CCD_OP_ZACC      3'h6
`define CCD_OP_DECSKIP   3'h7

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define CCD_RESP_OKAY    2'h0
`define CCD_RESP_SLVERR  2'h2
`define CCD_RESP_DECERR  2'h3

`endif

// *** verilog/ccd_pkg.sv ***
// types and shared functions of the clear/decrement/call executor
package ccd_pkg;

	typedef enum logic [1:0] {CCD_IDLE, CCD_EXEC, CCD_SECOND} ccd_state_e;

	typedef struct packed {
		logic [6:0] faddr;
		logic       dest;
		logic [2:0] op;
	} ccd_instr_s;

	typedef struct packed {
		logic [7:0] data;
		logic       to_acc;
		logic       to_file;
		logic       upd_z;
		logic       z;
		logic       skip;
	} ccd_result_s;

	function automatic logic ccd_is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	function automatic logic [31:0] ccd_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// *** verilog/ccd_exec_unit.sv ***
// combinational result of one issued operation
`timescale 1ns/1ps
module ccd_exec_unit
	import ccd_pkg::*;
(
	input  wire ccd_instr_s  instr,  // operation being executed
	input  wire logic [7:0]  fval,   // addressed register contents
	output ccd_result_s      res     // result and its routing
);
`include "ccd_defines.svh"

	wire logic [7:0] dec_v = fval - 8'h01;

	always_comb begin
		res = '0;
		unique case (instr.op)
			`CCD_OP_INV: begin
				res.data    = ~fval;
				res.to_acc  = ~instr.dest;
				res.to_file = instr.dest;
				res.upd_z   = 1'b1;
				res.z       = ccd_is_zero(~fval);
			end
			`CCD_OP_ZREG: begin
				res.to_file = 1'b1;
				res.upd_z   = 1'b1;
				res.z       = 1'b1;
			end
			`CCD_OP_DEC: begin
				res.data    = dec_v;
				res.to_acc  = ~instr.dest;
				res.to_file = instr.dest;
				res.upd_z   = 1'b1;
				res.z       = ccd_is_zero(dec_v);
			end
			`CCD_OP_ZACC: begin
				res.to_acc = 1'b1;
				res.upd_z  = 1'b1;
				res.z      = 1'b1;
			end
			`CCD_OP_DECSKIP: begin
				res.data    = dec_v;
				res.to_acc  = ~instr.dest;
				res.to_file = instr.dest;
				res.skip    = ccd_is_zero(dec_v);
			end
			`CCD_OP_NONE, `CCD_OP_WDCLR, `CCD_OP_ACALL: begin
				res = '0;
			end
		endcase
	end

endmodule

// *** verilog/ccd_core.sv ***
// executor for watchdog clear, accumulator call, invert, clear and decrement ops
//
// How it works
// - watchdog clear zeroes counter and prescaler
// - watchdog clear sets expiry and power-down flags
// - accumulator call pushes pc plus one
// - then pc gets high latch and accumulator
// - accumulator call: two cycles, flags unchanged
// - invert register, route by dest, update zero
// - clear register, zero flag set
// - decrement register, route by dest, update zero
// - clear accumulator, zero flag set
// - decrement-skip routes result, only the skip flag updated
// - zero result discards next op, two cycles
`timescale 1ns/1ps
module ccd_core
	import ccd_pkg::*;
(
	input  wire logic        aclk,           // core clock, 40 MHz
	input  wire logic        aresetn,        // synchronous reset, active low
	input  wire logic [7:0]  s_awaddr,       // write address
	input  wire logic        s_awvalid,      // write address valid
	output logic             s_awready,      // write address ready
	input  wire logic [31:0] s_wdata,        // write data
	input  wire logic [3:0]  s_wstrb,        // write byte enables
	input  wire logic        s_wvalid,       // write data valid
	output logic             s_wready,       // write data ready
	output logic [1:0]       s_bresp,        // write response
	output logic             s_bvalid,       // write response valid
	input  wire logic        s_bready,       // write response ready
	input  wire logic [7:0]  s_araddr,       // read address
	input  wire logic        s_arvalid,      // read address valid
	output logic             s_arready,      // read address ready
	output logic [31:0]      s_rdata,        // read data
	output logic [1:0]       s_rresp,        // read response
	output logic             s_rvalid,       // read data valid
	input  wire logic        s_rready        // read data ready
);
`include "ccd_defines.svh"

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ccd_state_e  state_r, state_nxt;
	ccd_instr_s  instr_r;
	ccd_result_s res;
	logic [7:0]  acc_r, faddr_r, wdt_r, presc_r;
	logic [14:0] pc_r;
	logic [6:0]  pch_r;
	logic        z_r, to_r, pd_r, skip_r;
	logic [3:0]  sp_r;
	logic [4:0]  depth_r;
	logic [7:0]  file_mem  [128];
	logic [14:0] stack_mem [16];
	logic        aw_got_r, w_got_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	wire logic aw_hs     = s_awvalid & s_awready;
	wire logic w_hs      = s_wvalid & s_wready;
	wire logic wr_fire   = aw_got_r & w_got_r & ~s_bvalid;
	wire logic aw_got_nxt = ~wr_fire & (aw_got_r | aw_hs);
	wire logic w_got_nxt  = ~wr_fire & (w_got_r | w_hs);
	wire logic bvalid_nxt = wr_fire | (s_bvalid & ~s_bready);
	wire logic busy      = state_r != CCD_IDLE;

	wire logic wa_issue = awaddr_r == `CCD_REG_ISSUE;
	wire logic wa_acc   = awaddr_r == `CCD_REG_ACC;
	wire logic wa_pc    = awaddr_r == `CCD_REG_PC;
	wire logic wa_pch   = awaddr_r == `CCD_REG_PCH;
	wire logic wa_stat  = awaddr_r == `CCD_REG_STAT;
	wire logic wa_faddr = awaddr_r == `CCD_REG_FADDR;
	wire logic wa_fdata = awaddr_r == `CCD_REG_FDATA;
	wire logic wa_map   = wa_issue | wa_acc | wa_pc | wa_pch | wa_stat | wa_faddr
		| wa_fdata;
	wire logic wr_ok    = wr_fire & wa_map & ~busy;
	wire logic [1:0] wr_resp = ~wa_map ? `CCD_RESP_DECERR :
		busy ? `CCD_RESP_SLVERR : `CCD_RESP_OKAY;

	// merged words keep bytes whose enable is low
	wire logic [31:0] m_issue = ccd_merge({21'h0, instr_r}, wdata_r, wstrb_r);
	wire logic [31:0] m_acc   = ccd_merge({24'h0, acc_r}, wdata_r, wstrb_r);
	wire logic [31:0] m_pc    = ccd_merge({17'h0, pc_r}, wdata_r, wstrb_r);
	wire logic [31:0] m_pch   = ccd_merge({25'h0, pch_r}, wdata_r, wstrb_r);
	wire logic [31:0] m_stat  = ccd_merge({29'h0, to_r, pd_r, z_r}, wdata_r, wstrb_r);
	wire logic [31:0] m_faddr = ccd_merge({24'h0, faddr_r}, wdata_r, wstrb_r);
	wire logic [7:0]  fdata_v = wstrb_r[0] ? wdata_r[7:0] : file_mem[faddr_r[6:0]];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= `CCD_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				awaddr_r <= s_awaddr;
			end
			if (w_hs) begin
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_fire) begin
				s_bresp <= wr_resp;
			end
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			s_bvalid  <= bvalid_nxt;
			s_awready <= ~aw_got_nxt & ~bvalid_nxt;
			s_wready  <= ~w_got_nxt & ~bvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	wire logic [14:0] stack_top  = stack_mem[4'(sp_r - 4'h1)];
	wire logic [31:0] stat_word  = {22'h0, depth_r, skip_r, busy, to_r, pd_r, z_r};
	wire logic ar_hs      = s_arvalid & s_arready;
	wire logic rvalid_nxt = ar_hs | (s_rvalid & ~s_rready);
	wire logic [31:0] rd_word =
		(s_araddr == `CCD_REG_ISSUE) ? {21'h0, instr_r} :
		(s_araddr == `CCD_REG_ACC)   ? {24'h0, acc_r} :
		(s_araddr == `CCD_REG_PC)    ? {17'h0, pc_r} :
		(s_araddr == `CCD_REG_PCH)   ? {25'h0, pch_r} :
		(s_araddr == `CCD_REG_STAT)  ? stat_word :
		(s_araddr == `CCD_REG_FADDR) ? {24'h0, faddr_r} :
		(s_araddr == `CCD_REG_FDATA) ? {24'h0, file_mem[faddr_r[6:0]]} :
		(s_araddr == `CCD_REG_WDT)   ? {24'h0, wdt_r} :
		(s_araddr == `CCD_REG_TOP)   ? {17'h0, stack_top} : 32'h0000_0000;
	wire logic rd_map = (s_araddr[1:0] == 2'h0) && (s_araddr <= `CCD_REG_TOP);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= `CCD_RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_rdata <= rd_word;
				s_rresp <= rd_map ? `CCD_RESP_OKAY : `CCD_RESP_DECERR;
			end
			s_rvalid  <= rvalid_nxt;
			s_arready <= ~rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// execution
	// ----------------------------------------------------------------
	wire logic [7:0]  fval      = file_mem[instr_r.faddr];
	wire logic        exec      = state_r == CCD_EXEC;
	wire logic        second    = state_r == CCD_SECOND;
	wire logic        op_wdclr  = instr_r.op == `CCD_OP_WDCLR;
	wire logic        op_call   = instr_r.op == `CCD_OP_ACALL;
	wire logic        op_dskip  = instr_r.op == `CCD_OP_DECSKIP;
	wire logic        wd_clear  = exec & op_wdclr;
	wire logic        presc_end = presc_r == 8'hFF;
	wire logic        wdt_ovf   = presc_end & (wdt_r == 8'hFF);
	wire logic [14:0] pc_inc    = 15'(pc_r + 15'h0001);
	wire logic        we_issue  = wr_ok & wa_issue;
	wire logic        we_stat   = wr_ok & wa_stat;

	ccd_exec_unit u_exec (
		.instr (instr_r),
		.fval  (fval),
		.res   (res)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CCD_IDLE:   state_nxt = we_issue ? CCD_EXEC : CCD_IDLE;
			CCD_EXEC:   state_nxt = (op_call | res.skip) ? CCD_SECOND : CCD_IDLE;
			CCD_SECOND: state_nxt = CCD_IDLE;
			default:    state_nxt = CCD_IDLE;
		endcase
	end

	wire logic [7:0] acc_nxt = (exec & res.to_acc) ? res.data :
		(wr_ok & wa_acc) ? m_acc[7:0] : acc_r;
	// call: push in the first cycle, jump in the second; skip: step over the fetched op
	wire logic [14:0] pc_nxt = (exec & ~op_call) ? pc_inc :
		(second & op_call) ? {pch_r, acc_r} :
		second ? pc_inc :
		(wr_ok & wa_pc) ? m_pc[14:0] : pc_r;
	wire logic z_nxt  = (exec & res.upd_z) ? res.z :
		we_stat ? m_stat[`CCD_ST_Z] : z_r;
	// hardware overflow clear beats a software set landing in the same cycle
	wire logic to_nxt = wd_clear ? 1'b1 : wdt_ovf ? 1'b0 :
		we_stat ? m_stat[`CCD_ST_TO] : to_r;
	wire logic pd_nxt = wd_clear ? 1'b1 : we_stat ? m_stat[`CCD_ST_PD] : pd_r;
	wire logic [7:0] wdt_nxt = wd_clear ? 8'h00 :
		presc_end ? 8'(wdt_r + 8'h01) : wdt_r;
	wire logic [7:0] presc_nxt = wd_clear ? 8'h00 : 8'(presc_r + 8'h01);
	wire logic push = exec & op_call;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CCD_IDLE;
			instr_r <= '0;
			acc_r   <= 8'h00;
			pc_r    <= 15'h0000;
			pch_r   <= 7'h00;
			faddr_r <= 8'h00;
			z_r     <= `CCD_RST_Z;
			to_r    <= `CCD_RST_TO;
			pd_r    <= `CCD_RST_PD;
			skip_r  <= 1'b0;
			wdt_r   <= 8'h00;
			presc_r <= 8'h00;
			sp_r    <= 4'h0;
			depth_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			acc_r   <= acc_nxt;
			pc_r    <= pc_nxt;
			z_r     <= z_nxt;
			to_r    <= to_nxt;
			pd_r    <= pd_nxt;
			wdt_r   <= wdt_nxt;
			presc_r <= presc_nxt;
			if (we_issue) begin
				instr_r <= ccd_instr_s'(m_issue[10:0]);
			end
			if (wr_ok & wa_pch) begin
				pch_r <= m_pch[6:0];
			end
			if (wr_ok & wa_faddr) begin
				faddr_r <= {1'b0, m_faddr[6:0]};
			end
			if (exec & op_dskip) begin
				skip_r <= res.skip;
			end
			// deepest level wraps over the oldest entry; depth saturates
			if (push) begin
				sp_r <= 4'(sp_r + 4'h1);
				if (depth_r != `CCD_STACK_DEPTH) begin
					depth_r <= 5'(depth_r + 5'h01);
				end
			end
		end
	end

	// memories carry no reset
	always_ff @(posedge aclk) begin
		if (push) begin
			stack_mem[sp_r] <= pc_inc;
		end
		if (exec & res.to_file) begin
			file_mem[instr_r.faddr] <= res.data;
		end else if (wr_ok & wa_fdata) begin
			file_mem[faddr_r[6:0]] <= fdata_v;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire logic is_inv  = exec & (instr_r.op == `CCD_OP_INV);
	wire logic is_zreg = exec & (instr_r.op == `CCD_OP_ZREG);
	wire logic is_dec  = exec & (instr_r.op == `CCD_OP_DEC);
	wire logic is_zacc = exec & (instr_r.op == `CCD_OP_ZACC);
	wire logic is_dsk  = exec & op_dskip;

	sequence s_call_two;
		(state_r == CCD_SECOND) ##1 (state_r == CCD_IDLE);
	endsequence

	property p_wd_zero;
		wd_clear |=> (wdt_r == 8'h00) && (presc_r == 8'h00);
	endproperty
	a_wd_zero: assert property (p_wd_zero) else $error("watchdog not zeroed");

	property p_wd_flags;
		wd_clear |=> to_r && pd_r && (z_r == $past(z_r));
	endproperty
	a_wd_flags: assert property (p_wd_flags) else $error("watchdog flags wrong");

	property p_call_push;
		push |=> (stack_top == 15'($past(pc_r) + 15'h0001)) && (depth_r != 5'h00);
	endproperty
	a_call_push: assert property (p_call_push) else $error("return address wrong");

	property p_call_jump;
		push |=> ##1 pc_r == {$past(pch_r, 2), $past(acc_r, 2)};
	endproperty
	a_call_jump: assert property (p_call_jump) else $error("call target wrong");

	property p_call_cycles;
		push |=> s_call_two and ($stable(z_r) && $stable(pd_r)
			&& ($stable(to_r) || $past(wdt_ovf))) [*2];
	endproperty
	a_call_cycles: assert property (p_call_cycles) else $error("call timing wrong");

	property p_invert;
		is_inv && !instr_r.dest |=> acc_r == ~$past(fval);
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_zero_reg;
		is_zreg |=> z_r && (file_mem[$past(instr_r.faddr)] == 8'h00);
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("register not cleared");

	property p_dec_file;
		is_dec && instr_r.dest |=> file_mem[$past(instr_r.faddr)] == 8'($past(fval) - 8'h01);
	endproperty
	a_dec_file: assert property (p_dec_file) else $error("decrement wrong");

	property p_zero_acc;
		is_zacc |=> (acc_r == 8'h00) && z_r;
	endproperty
	a_zero_acc: assert property (p_zero_acc) else $error("accumulator not cleared");

	property p_dskip_flags;
		is_dsk |=> $stable(z_r) && $stable(pd_r) && ($stable(to_r) || $past(wdt_ovf));
	endproperty
	a_dskip_flags: assert property (p_dskip_flags) else $error("skip changed flags");

	property p_dskip_skip;
		is_dsk && (fval == 8'h01) |=> (state_r == CCD_SECOND) ##1
			(pc_r == 15'($past(pc_r, 2) + 15'h0002));
	endproperty
	a_dskip_skip: assert property (p_dskip_skip) else $error("skip not taken");

	property p_zero_flag;
		exec && res.upd_z |=> z_r == ($past(res.data) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

endmodule

// *** verif/cpu_clear_dec_call_ops_tb.sv ***
// self-checking bench for the clear/decrement/call executor over its register bus
`timescale 1ns/1ps
`include "ccd_defines.svh"
module cpu_clear_dec_call_ops_tb;
	import ccd_pkg::*;

	// ----------------------------------------------------------------
	// clock, reset and bus signals
	// ----------------------------------------------------------------
	logic        aclk;
	logic        aresetn;
	logic [7:0]  s_awaddr;
	logic        s_awvalid;
	logic        s_awready;
	logic [31:0] s_wdata;
	logic [3:0]  s_wstrb;
	logic        s_wvalid;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic        s_bready;
	logic [7:0]  s_araddr;
	logic        s_arvalid;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic        s_rready;
	int          n_errors;
	int          checks;
	logic [1:0]  rsp;
	logic [31:0] rv;

	ccd_core ccd_core_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// an extra edge up front keeps bready/rready from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h1;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) begin
				r = s_bresp;
				s_bready <= 1'b0;
				break;
			end
		end
		if (n >= 200) chk("write answer", 32'h0, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		d = '0;
		r = 2'h1;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) begin
				d = s_rdata;
				r = s_rresp;
				s_rready <= 1'b0;
				break;
			end
		end
		if (n >= 200) chk("read answer", 32'h0, 32'h1);
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rsp);
		chk("write resp", {30'h0, rsp}, {30'h0, `CCD_RESP_OKAY});
	endtask

	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd(a, rv, rsp);
		chk(what, rv, exp);
	endtask

	// issue one op, then wait for the executor to go idle
	task automatic issue(input logic [2:0] op, input logic d, input logic [6:0] f);
		int n;
		w(`CCD_REG_ISSUE, {21'h0, f, d, op});
		n = 0;
		do begin
			rd(`CCD_REG_STAT, rv, rsp);
			n++;
		end while (rv[`CCD_ST_BUSY] !== 1'b0 && n < 20);
		chk("exec idle", {31'h0, rv[`CCD_ST_BUSY]}, 32'h0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(25ns * 20000);
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// operand table: op, dest, reg, value, z before, result, z after, pc step
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] op;
		logic       d;
		logic [6:0] f;
		logic [7:0] v;
		logic       zp;
		logic [7:0] res;
		logic       z;
		logic [1:0] pci;
	} ccd_case_s;
	ccd_case_s tbl [9];
	initial begin
		tbl[0] = {`CCD_OP_INV, 1'b0, 7'h05, 8'hFF, 1'b0, 8'h00, 1'b1, 2'h1};
		tbl[1] = {`CCD_OP_INV, 1'b1, 7'h7F, 8'h0F, 1'b1, 8'hF0, 1'b0, 2'h1};
		tbl[2] = {`CCD_OP_DEC, 1'b0, 7'h03, 8'h01, 1'b0, 8'h00, 1'b1, 2'h1};
		tbl[3] = {`CCD_OP_DEC, 1'b1, 7'h03, 8'h00, 1'b1, 8'hFF, 1'b0, 2'h1};
		tbl[4] = {`CCD_OP_ZREG, 1'b0, 7'h09, 8'h5A, 1'b0, 8'h00, 1'b1, 2'h1};
		tbl[5] = {`CCD_OP_ZACC, 1'b0, 7'h0A, 8'h33, 1'b0, 8'h00, 1'b1, 2'h1};
		// zero flag clear against the zero result, so an update would show
		tbl[6] = {`CCD_OP_DECSKIP, 1'b1, 7'h11, 8'h01, 1'b0, 8'h00, 1'b0, 2'h2};
		tbl[7] = {`CCD_OP_DECSKIP, 1'b0, 7'h12, 8'h02, 1'b1, 8'h01, 1'b1, 2'h1};
		tbl[8] = {`CCD_OP_NONE, 1'b0, 7'h13, 8'h44, 1'b1, 8'h77, 1'b1, 2'h1};
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		checks = 0;
		aresetn = 1'b0;
		{s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
		s_wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rc("stat reset", `CCD_REG_STAT, 32'h0000_0006);
		rc("acc reset", `CCD_REG_ACC, 32'h0000_0000);
		$display("test reset done");

		// let the watchdog count past zero first, so the clear has work to do
		w(`CCD_REG_STAT, 32'h0000_0001);
		repeat (600) @(posedge aclk);
		rd(`CCD_REG_WDT, rv, rsp);
		chk("wdt running", {31'h0, rv == 32'h0}, 32'h0);
		issue(`CCD_OP_WDCLR, 1'b0, 7'h00);
		rc("wdt cleared", `CCD_REG_WDT, 32'h0000_0000);
		rc("stat after wdclr", `CCD_REG_STAT, 32'h0000_0007);
		// cleared prescaler holds the counter at zero for a full prescale period
		repeat (230) @(posedge aclk);
		rc("wdt held", `CCD_REG_WDT, 32'h0000_0000);
		repeat (20) @(posedge aclk);
		rc("wdt counts again", `CCD_REG_WDT, 32'h0000_0001);
		$display("test watchdog clear done");

		// call through accumulator: push pc plus one, jump to latch:acc
		w(`CCD_REG_PCH, 32'h0000_0055);
		w(`CCD_REG_ACC, 32'h0000_00A3);
		w(`CCD_REG_PC, 32'h0000_1234);
		w(`CCD_REG_STAT, 32'h0000_0001);
		issue(`CCD_OP_ACALL, 1'b0, 7'h00);
		rc("stack top", `CCD_REG_TOP, 32'h0000_1235);
		rc("call pc", `CCD_REG_PC, 32'h0000_55A3);
		rc("call stat", `CCD_REG_STAT, 32'h0000_0021);
		$display("test accumulator call done");

		foreach (tbl[i]) begin
			w(`CCD_REG_FADDR, {25'h0, tbl[i].f});
			w(`CCD_REG_FDATA, {24'h0, tbl[i].v});
			w(`CCD_REG_ACC, 32'h0000_0077);
			w(`CCD_REG_PC, 32'h0000_0100);
			w(`CCD_REG_STAT, {31'h0, tbl[i].zp});
			issue(tbl[i].op, tbl[i].d, tbl[i].f);
			rd(`CCD_REG_STAT, rv, rsp);
			chk("zero flag", {31'h0, rv[`CCD_ST_Z]}, {31'h0, tbl[i].z});
			if (tbl[i].op == `CCD_OP_DECSKIP) begin
				chk("skip flag", {31'h0, rv[`CCD_ST_SKIP]}, {31'h0, tbl[i].pci == 2'h2});
			end
			rc("pc step", `CCD_REG_PC, 32'h0000_0100 + tbl[i].pci);
			if (tbl[i].op == `CCD_OP_ZACC) begin
				rc("acc", `CCD_REG_ACC, 32'h0000_0000);
				rc("reg kept", `CCD_REG_FDATA, {24'h0, tbl[i].v});
			end else if (tbl[i].d || tbl[i].op == `CCD_OP_ZREG) begin
				rc("reg", `CCD_REG_FDATA, {24'h0, tbl[i].res});
				rc("acc kept", `CCD_REG_ACC, 32'h0000_0077);
			end else begin
				rc("acc", `CCD_REG_ACC, {24'h0, tbl[i].res});
				rc("reg kept", `CCD_REG_FDATA, {24'h0, tbl[i].v});
			end
		end
		$display("test register ops done");

		// unmapped and unaligned places are refused
		wr(8'h24, 32'h0000_0001, rsp);
		chk("unmapped write", {30'h0, rsp}, {30'h0, `CCD_RESP_DECERR});
		rd(8'h24, rv, rsp);
		chk("unmapped read", {30'h0, rsp}, {30'h0, `CCD_RESP_DECERR});
		chk("unmapped data", rv, 32'h0);
		rd(8'h02, rv, rsp);
		chk("unaligned read", {30'h0, rsp}, {30'h0, `CCD_RESP_DECERR});
		$display("test bus errors done");
		report_and_stop();
	end
endmodule
